//--- logic/supply_cmd_map.svh
// Named offsets, field positions, widths and reset values of the command block.
// Assumes it is included by the package, the command core and the bench files.
`ifndef SUPPLY_CMD_MAP_SVH
`define SUPPLY_CMD_MAP_SVH

// ****************************************************************
// Register offsets on the plain software port (byte addresses).
// ****************************************************************
`define ADDR_W 4
`define DATA_W 32
`define REG_IRQ_STATUS 4'h0
`define REG_IRQ_MASK 4'h4
`define REG_STATE 4'h8
`define REG_ACC_PEEK 4'hc

// ****************************************************************
// Event bits of the interrupt status and mask registers.
// ****************************************************************
`define EV_W 3
`define EV_REPLY 0
`define EV_CLEAR 1
`define EV_APPLY 2
`define EV_NONE 3'h0
`define MASK_RESET 3'h0

// ****************************************************************
// Fields of the state register.
// ****************************************************************
`define ST_AUX1 0
`define ST_AUX2 1
`define ST_CAL 2
`define ST_REMOTE 3
`define ST_PENDING 4

// ****************************************************************
// Reply value width and the default width of the live status word.
// ****************************************************************
`define REPLY_W 16
`define STATUS_W_DEF 8
`define SETTING_OFF 1'b0
`define PIN_INACTIVE 1'b1

`endif

//--- logic/supply_cmd_pkg.sv
// Types shared by the command core and whoever drives its ports.
// Assumes a parser upstream has turned command text into codes.
`default_nettype none
package supply_cmd_pkg;
`include "supply_cmd_map.svh"

    // Commands and replies handled by this block.
    typedef enum logic [2:0] {
        CMD_ACC_QUERY = 3'h0,
        CMD_AUX1_SET = 3'h1,
        CMD_AUX1_QUERY = 3'h2,
        CMD_AUX2_SET = 3'h3,
        CMD_AUX2_QUERY = 3'h4,
        CMD_CLEAR = 3'h5,
        CMD_CAL_SET = 3'h6,
        CMD_CAL_QUERY = 3'h7
    } cmd_code_type;

    // One decoded command; arg is 1 for 1/ON and 0 for 0/OFF.
    typedef struct packed {
        logic valid;
        cmd_code_type code;
        logic arg;
    } cmd_type;

    // One reply; the keyword is given by kind, the number by value.
    typedef struct packed {
        logic valid;
        cmd_code_type kind;
        logic [`REPLY_W-1:0] value;
    } reply_type;

    // One access of the software port.
    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    // Deferred clear sequencing, one bit changing from CLR_IDLE to CLR_WAIT to CLR_APPLY.
    typedef enum logic [1:0] {
        CLR_IDLE = 2'h0,
        CLR_WAIT = 2'h1,
        CLR_APPLY = 2'h3
    } clr_state_type;

endpackage
`default_nettype wire

//--- logic/supply_cmd_core.sv
// Command core for status capture, auxiliary outputs, clear and calibration mode.
// Assumes decoded commands and the software port share sys_clk; live status
// and the remote pin come from outside and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "supply_cmd_map.svh"

module supply_cmd_core
#(
    parameter int STATUS_W = `STATUS_W_DEF
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire supply_cmd_pkg::cmd_type cmd,
    output var supply_cmd_pkg::reply_type reply,
    input wire logic [STATUS_W-1:0] status_live_pin,
    input wire logic remote_pin,
    output logic aux_first_n,
    output logic aux_second_n,
    output logic cal_mode,
    output logic fault_clear,
    output logic defaults_load,
    output logic defaults_apply,
    input wire supply_cmd_pkg::bus_req_type bus,
    output logic [`DATA_W-1:0] rd_data,
    output logic irq
);

    // ****************************************************************
    // Elaboration check
    // ****************************************************************

    // The reply number cannot hold more status bits than its width.
    if (STATUS_W < 1 || STATUS_W > `REPLY_W)
    begin : g_bad_width
        $error("STATUS_W must lie between 1 and the reply width.");
    end

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************

    logic [STATUS_W-1:0] status_meta; // First stage, read by the second only.
    logic [STATUS_W-1:0] live_s; // Live status, safe to use.
    logic remote_meta; // First stage of the remote pin.
    logic remote_s; // High while the supply is in remote operation.

    // Two flops on every pin before any logic reads it.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_meta <= '0;
            live_s <= '0;
            remote_meta <= 1'b0;
            remote_s <= 1'b0;
        end
        else
        begin
            status_meta <= status_live_pin;
            live_s <= status_meta;
            remote_meta <= remote_pin;
            remote_s <= remote_meta;
        end
    end

    // ****************************************************************
    // Command decode
    // ****************************************************************

    wire take_acc = cmd.valid && cmd.code == supply_cmd_pkg::CMD_ACC_QUERY;
    wire take_aux1 = cmd.valid && cmd.code == supply_cmd_pkg::CMD_AUX1_SET;
    wire take_aux2 = cmd.valid && cmd.code == supply_cmd_pkg::CMD_AUX2_SET;
    wire take_clear = cmd.valid && cmd.code == supply_cmd_pkg::CMD_CLEAR;
    wire take_cal = cmd.valid && cmd.code == supply_cmd_pkg::CMD_CAL_SET;
    // Every query code makes a reply.
    wire take_query = take_acc
        || (cmd.valid && cmd.code == supply_cmd_pkg::CMD_AUX1_QUERY)
        || (cmd.valid && cmd.code == supply_cmd_pkg::CMD_AUX2_QUERY)
        || (cmd.valid && cmd.code == supply_cmd_pkg::CMD_CAL_QUERY);

    // ****************************************************************
    // Accumulated status capture
    // ****************************************************************

    logic [STATUS_W-1:0] acc; // Sticky copy of the live status.
    wire [STATUS_W-1:0] acc_view = acc | live_s; // What a query reports now.

    // same bit layout
    // Bit i of the capture follows bit i of the live word, weight for weight.
    for (genvar i = 0; i < STATUS_W; i++)
    begin : g_acc
        // sticky capture, restart
        // A query reloads from live status, so a bit set that cycle is kept.
        always_ff @(posedge sys_clk or negedge resetn)
        begin
            if (!resetn)
                acc[i] <= 1'b0;
            else if (take_acc)
                acc[i] <= live_s[i];
            else
                acc[i] <= acc[i] | live_s[i];
        end
    end

    // ****************************************************************
    // Settings
    // ****************************************************************

    logic aux1; // Stored first auxiliary setting.
    logic aux2; // Stored second auxiliary setting.

    // Clear loads defaults into aux1 and aux2, not cal_mode, whatever the control mode.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aux1 <= `SETTING_OFF;
            aux2 <= `SETTING_OFF;
            cal_mode <= `SETTING_OFF;
        end
        else
        begin
            if (take_clear)
            begin
                aux1 <= `SETTING_OFF;
                aux2 <= `SETTING_OFF;
            end
            else if (take_aux1)
                aux1 <= cmd.arg;
            else if (take_aux2)
                aux2 <= cmd.arg;
            if (take_cal)
                cal_mode <= cmd.arg;
        end
    end

    // ****************************************************************
    // Auxiliary output pins
    // ****************************************************************

    // active low pins
    // Pins follow the settings only under remote control, so defaults
    // loaded in local mode reach them when remote operation resumes.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            aux_first_n <= `PIN_INACTIVE;
            aux_second_n <= `PIN_INACTIVE;
        end
        else if (remote_s)
        begin
            aux_first_n <= ~aux1;
            aux_second_n <= ~aux2;
        end
    end

    // ****************************************************************
    // Clear sequencing
    // ****************************************************************

    supply_cmd_pkg::clr_state_type clr_state; // Where a clear stands.
    supply_cmd_pkg::clr_state_type next_clr_state; // Its next value.

    // deferred apply
    // A clear in local mode waits until the remote pin goes high.
    always_comb
    begin
        next_clr_state = clr_state;
        case (clr_state)
            supply_cmd_pkg::CLR_IDLE:
            begin
                if (take_clear)
                    next_clr_state = remote_s ? supply_cmd_pkg::CLR_APPLY
                                              : supply_cmd_pkg::CLR_WAIT;
            end
            supply_cmd_pkg::CLR_WAIT:
            begin
                if (remote_s)
                    next_clr_state = supply_cmd_pkg::CLR_APPLY;
            end
            supply_cmd_pkg::CLR_APPLY:
            begin
                // A new clear restarts the sequence.
                if (take_clear && !remote_s)
                    next_clr_state = supply_cmd_pkg::CLR_WAIT;
                else if (!take_clear)
                    next_clr_state = supply_cmd_pkg::CLR_IDLE;
            end
            default:
                next_clr_state = supply_cmd_pkg::CLR_IDLE;
        endcase
    end

    // State register and the one-cycle strobes to the supply.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clr_state <= supply_cmd_pkg::CLR_IDLE;
            fault_clear <= 1'b0;
            defaults_load <= 1'b0;
            defaults_apply <= 1'b0;
        end
        else
        begin
            clr_state <= next_clr_state;
            fault_clear <= take_clear;
            defaults_load <= take_clear;
            defaults_apply <= clr_state == supply_cmd_pkg::CLR_APPLY;
        end
    end

    // ****************************************************************
    // Replies
    // ****************************************************************

    logic [`REPLY_W-1:0] reply_mux; // Number for the current query.

    // reply numbers
    // The capture as a binary number equals the sum of the set weights.
    always_comb
    begin
        reply_mux = '0;
        case (cmd.code)
            supply_cmd_pkg::CMD_ACC_QUERY: reply_mux = `REPLY_W'(acc_view);
            supply_cmd_pkg::CMD_AUX1_QUERY: reply_mux = `REPLY_W'(aux1);
            supply_cmd_pkg::CMD_AUX2_QUERY: reply_mux = `REPLY_W'(aux2);
            supply_cmd_pkg::CMD_CAL_QUERY: reply_mux = `REPLY_W'(cal_mode);
            default: reply_mux = '0;
        endcase
    end

    // one reply held
    // A new query overwrites the held reply; the host reads it first.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            reply <= '0;
        else
        begin
            reply.valid <= take_query;
            if (take_query)
            begin
                reply.kind <= cmd.code;
                reply.value <= reply_mux;
            end
        end
    end

    // ****************************************************************
    // Software registers and interrupt
    // ****************************************************************

    logic [`EV_W-1:0] irq_status; // Sticky events, cleared by a read.
    logic [`EV_W-1:0] irq_mask; // One enables the matching event.
    logic [`EV_W-1:0] events; // Events of this cycle.

    assign events[`EV_REPLY] = take_query;
    assign events[`EV_CLEAR] = take_clear;
    assign events[`EV_APPLY] = clr_state == supply_cmd_pkg::CLR_APPLY;

    wire rd_status = bus.rd && bus.addr == `REG_IRQ_STATUS;
    wire wr_mask = bus.wr && bus.addr == `REG_IRQ_MASK;
    // A set in the clearing cycle wins over the clear.
    wire [`EV_W-1:0] next_irq_status = (rd_status ? `EV_NONE : irq_status) | events;

    logic [`DATA_W-1:0] state_word; // Block state for software.
    always_comb
    begin
        state_word = '0;
        state_word[`ST_AUX1] = aux1;
        state_word[`ST_AUX2] = aux2;
        state_word[`ST_CAL] = cal_mode;
        state_word[`ST_REMOTE] = remote_s;
        state_word[`ST_PENDING] = clr_state == supply_cmd_pkg::CLR_WAIT;
    end

    // Read mux; unmapped offsets read as zero.
    wire [`DATA_W-1:0] rd_mux =
        bus.addr == `REG_IRQ_STATUS ? `DATA_W'(irq_status) :
        bus.addr == `REG_IRQ_MASK ? `DATA_W'(irq_mask) :
        bus.addr == `REG_STATE ? state_word :
        bus.addr == `REG_ACC_PEEK ? `DATA_W'(acc) : '0;

    // Registers, read data one cycle after the strobe and the interrupt.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_status <= `EV_NONE;
            irq_mask <= `MASK_RESET;
            rd_data <= '0;
            irq <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            if (wr_mask)
                irq_mask <= bus.wdata[`EV_W-1:0];
            rd_data <= bus.rd ? rd_mux : '0;
            irq <= |(next_irq_status & irq_mask);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    chk_acc_sticky_hold: assert property (
        !take_acc |=> (acc & $past(live_s)) == $past(live_s))
        else $error("Accumulated bit lost a live status event.");

    chk_acc_restart_point: assert property (
        take_acc |=> acc == $past(live_s))
        else $error("Accumulated capture did not restart after query.");

    chk_acc_reply_sum: assert property (
        take_acc |=> reply.valid && reply.value == `REPLY_W'($past(acc_view)))
        else $error("Accumulated reply value is wrong.");

    chk_aux_first_pin: assert property (
        $past(remote_s) |-> aux_first_n == !$past(aux1))
        else $error("First aux pin does not follow its setting.");

    chk_aux_second_pin: assert property (
        $past(remote_s) |-> aux_second_n == !$past(aux2))
        else $error("Second aux pin does not follow its setting.");

    chk_aux_query_reply: assert property (
        cmd.valid && cmd.code == supply_cmd_pkg::CMD_AUX1_QUERY
        |=> reply.valid && reply.value == `REPLY_W'($past(aux1)))
        else $error("First aux query reply is wrong.");

    chk_aux_second_reply: assert property (
        cmd.valid && cmd.code == supply_cmd_pkg::CMD_AUX2_QUERY
        |=> reply.value == `REPLY_W'($past(aux2)))
        else $error("Second aux query reply is wrong.");

    chk_cal_query_reply: assert property (
        cmd.valid && cmd.code == supply_cmd_pkg::CMD_CAL_QUERY
        |=> reply.value == `REPLY_W'($past(cal_mode)))
        else $error("Calibration query reply is wrong.");

    chk_cal_mode_set: assert property (
        take_cal |=> cal_mode == $past(cmd.arg))
        else $error("Calibration mode did not take the argument.");

    chk_clear_keeps_cal: assert property (
        take_clear && !take_cal |=> $stable(cal_mode))
        else $error("Clear changed calibration mode.");

    chk_clear_defaults: assert property (
        take_clear |=> !aux1 && !aux2 && defaults_load)
        else $error("Clear did not restore the settings.");

    chk_clear_faults: assert property (
        take_clear |=> fault_clear ##1 !fault_clear || $past(take_clear))
        else $error("Clear did not empty the fault register.");

    chk_local_defer: assert property (
        take_clear && !remote_s && !remote_meta |=> ##1 !defaults_apply)
        else $error("Defaults applied while in local mode.");

    chk_remote_apply: assert property (
        take_clear && remote_s |=> ##1 defaults_apply)
        else $error("Defaults not applied under remote control.");

endmodule
`default_nettype wire

//--- tb/host_ctrl_model.sv
// Host controller model: sends decoded commands and reads each reply.
// Assumes it shares sys_clk with the command core and starts after reset.
`timescale 1ns/1ps
`default_nettype none
`include "supply_cmd_map.svh"

module host_ctrl_model
(
    input wire logic sys_clk,
    input wire logic resetn,
    output var supply_cmd_pkg::cmd_type cmd,
    input wire supply_cmd_pkg::reply_type reply
);
    // Number of queries whose reply never came back.
    int lost_replies = 0;

    // The command word is idle from time zero.
    initial
    begin
        cmd = '0;
    end

    // Sends one command with valid high for exactly one cycle.
    task automatic send(input supply_cmd_pkg::cmd_code_type code, input logic arg);
    begin
        // Waits out reset for a bounded number of edges only.
        for (int k = 0; k < 16 && resetn !== 1'b1; k++)
            @(posedge sys_clk);
        @(posedge sys_clk);
        cmd <= '{valid: 1'b1, code: code, arg: arg};
        @(posedge sys_clk);
        cmd <= '0;
    end
    endtask

    // Sends a query and collects its reply before anything else is sent.
    // reply read first
    task automatic query(input supply_cmd_pkg::cmd_code_type code,
                         output logic [`REPLY_W-1:0] value);
        int i;
        logic got;
    begin
        got = 1'b0;
        value = '1;
        send(code, 1'b0);
        for (i = 0; i < 8 && !got; i++)
        begin
            #1;
            if (reply.valid === 1'b1 && reply.kind === code)
            begin
                got = 1'b1;
                value = reply.value;
            end
            else
                @(posedge sys_clk);
        end
        if (!got)
            lost_replies++;
    end
    endtask
endmodule
`default_nettype wire

//--- tb/supply_status_aux_cal_commands_test.sv
// Self-checking bench for the command core with a host model on its command port.
// Assumes the core runs on one 25 MHz clock and answers queries within a few cycles.
`timescale 1ns/1ps
`default_nettype none
`include "supply_cmd_map.svh"

module supply_status_aux_cal_commands_test;
    // ****************************************************************
    // Clock, reset, stimulus and observed outputs.
    // ****************************************************************
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] status_live_pin = 8'h00;
    logic remote_pin = 1'b1;
    supply_cmd_pkg::bus_req_type bus = '0;
    supply_cmd_pkg::cmd_type cmd;
    supply_cmd_pkg::reply_type reply;
    logic aux_first_n, aux_second_n, cal_mode, fault_clear, defaults_load, defaults_apply, irq;
    logic [31:0] rd_data;
    logic [15:0] got;
    int num_errors = 0;
    int checks_done = 0;
    int n_fc = 0, n_load = 0, n_apply = 0;

    // The clock toggles every 20 ns, half of its 40 ns period.
    initial
    begin
        forever #20 sys_clk = ~sys_clk;
    end

    supply_cmd_core #(.STATUS_W(8)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .cmd(cmd),
        .reply(reply), .status_live_pin(status_live_pin), .remote_pin(remote_pin),
        .aux_first_n(aux_first_n), .aux_second_n(aux_second_n), .cal_mode(cal_mode),
        .fault_clear(fault_clear), .defaults_load(defaults_load),
        .defaults_apply(defaults_apply), .bus(bus), .rd_data(rd_data), .irq(irq));

    host_ctrl_model u_host (.sys_clk(sys_clk), .resetn(resetn), .cmd(cmd), .reply(reply));

    // Strobe pulses are counted on the falling edge, where they are settled.
    always @(negedge sys_clk)
    begin
        n_fc += (fault_clear === 1'b1);
        n_load += (defaults_load === 1'b1);
        n_apply += (defaults_apply === 1'b1);
    end

    // ****************************************************************
    // Shared helpers.
    // ****************************************************************
    // Compares one value and reports a mismatch at once.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    begin
        checks_done++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            num_errors++;
        end
    end
    endtask

    // Waits some edges, then lets their updates settle.
    task automatic cycles(input int n);
    begin
        repeat (n) @(posedge sys_clk);
        #1;
    end
    endtask

    // One-cycle register write.
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    begin
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
    end
    endtask

    // One-cycle register read; data stand in the following cycle only.
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    begin
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        #1;
        d = rd_data;
    end
    endtask

    // Prints the verdict and ends the run.
    task automatic finish_test;
    begin
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    // Power-on values of pins, settings and the mask.
    task automatic t_reset;
        logic [31:0] d;
    begin
        check("aux_first_n", 1, aux_first_n);
        check("aux_second_n", 1, aux_second_n);
        check("cal_mode", 0, cal_mode);
        u_host.query(supply_cmd_pkg::CMD_AUX1_QUERY, got);
        check("aux1 query", 0, got);
        u_host.query(supply_cmd_pkg::CMD_AUX2_QUERY, got);
        check("aux2 query", 0, got);
        u_host.query(supply_cmd_pkg::CMD_CAL_QUERY, got);
        check("cal query", 0, got);
        bus_rd(`REG_IRQ_MASK, d);
        check("mask reset", 0, d);
    end
    endtask

    // Sticky capture, weight sum, clear on query, single-cycle event.
    task automatic t_acc;
    begin
        @(posedge sys_clk);
        status_live_pin <= 8'h05;
        repeat (4) @(posedge sys_clk);
        status_live_pin <= 8'h00;
        cycles(4);
        u_host.query(supply_cmd_pkg::CMD_ACC_QUERY, got);
        check("acc sticky", 16'd5, got);
        u_host.query(supply_cmd_pkg::CMD_ACC_QUERY, got);
        check("acc cleared", 16'd0, got);
        @(posedge sys_clk);
        status_live_pin <= 8'h81;
        @(posedge sys_clk);
        status_live_pin <= 8'h00;
        cycles(4);
        u_host.query(supply_cmd_pkg::CMD_ACC_QUERY, got);
        check("acc short event", 16'd129, got);
        u_host.query(supply_cmd_pkg::CMD_ACC_QUERY, got);
        check("acc after clear", 16'd0, got);
    end
    endtask

    // Both aux outputs switched on and off, pins and queries.
    task automatic t_aux;
        int o, a;
    begin
        for (o = 0; o < 2; o++)
            for (a = 1; a >= 0; a--)
            begin
                u_host.send(o ? supply_cmd_pkg::CMD_AUX2_SET : supply_cmd_pkg::CMD_AUX1_SET,
                            1'(a));
                cycles(2);
                check("aux pin", 32'(!a), o ? aux_second_n : aux_first_n);
                check("other pin", 1, o ? aux_first_n : aux_second_n);
                u_host.query(o ? supply_cmd_pkg::CMD_AUX2_QUERY :
                             supply_cmd_pkg::CMD_AUX1_QUERY, got);
                check("aux query", 32'(a), got);
            end
    end
    endtask

    // Clear in remote: strobes, defaults, calibration untouched.
    task automatic t_clear_remote;
        int fc0, ld0, ap0;
    begin
        u_host.send(supply_cmd_pkg::CMD_AUX1_SET, 1'b1);
        u_host.send(supply_cmd_pkg::CMD_AUX2_SET, 1'b1);
        u_host.send(supply_cmd_pkg::CMD_CAL_SET, 1'b1);
        cycles(2);
        check("cal on", 1, cal_mode);
        u_host.query(supply_cmd_pkg::CMD_CAL_QUERY, got);
        check("cal query on", 1, got);
        fc0 = n_fc;
        ld0 = n_load;
        ap0 = n_apply;
        u_host.send(supply_cmd_pkg::CMD_CLEAR, 1'b0);
        cycles(4);
        check("fault clear", 1, n_fc - fc0);
        check("defaults load", 1, n_load - ld0);
        check("defaults apply", 1, n_apply - ap0);
        check("aux pins", 2'b11, {aux_first_n, aux_second_n});
        check("cal kept", 1, cal_mode);
        u_host.query(supply_cmd_pkg::CMD_AUX2_QUERY, got);
        check("aux2 cleared", 0, got);
        u_host.query(supply_cmd_pkg::CMD_CAL_QUERY, got);
        check("cal query kept", 1, got);
        u_host.send(supply_cmd_pkg::CMD_CAL_SET, 1'b0);
        cycles(2);
        check("cal off", 0, cal_mode);
    end
    endtask

    // Clear in local: defaults held back until remote returns.
    task automatic t_clear_local;
        logic [31:0] d;
        int fc0, ap0;
    begin
        @(posedge sys_clk);
        remote_pin <= 1'b0;
        cycles(4);
        u_host.send(supply_cmd_pkg::CMD_AUX1_SET, 1'b1);
        fc0 = n_fc;
        ap0 = n_apply;
        u_host.send(supply_cmd_pkg::CMD_CLEAR, 1'b0);
        cycles(10);
        check("local fault clear", 1, n_fc - fc0);
        check("local no apply", 0, n_apply - ap0);
        bus_rd(`REG_STATE, d);
        check("clear pending", 1, d[`ST_PENDING]);
        @(posedge sys_clk);
        remote_pin <= 1'b1;
        cycles(6);
        check("apply on remote", 1, n_apply - ap0);
        check("aux1 pin idle", 1, aux_first_n);
    end
    endtask

    // Interrupt raise, read-clear, mask, unmapped and read-only places.
    task automatic t_irq;
        logic [31:0] d;
    begin
        bus_rd(`REG_IRQ_STATUS, d);
        bus_wr(`REG_IRQ_MASK, 32'h1);
        u_host.query(supply_cmd_pkg::CMD_CAL_QUERY, got);
        cycles(3);
        check("irq raised", 1, irq);
        bus_rd(`REG_IRQ_STATUS, d);
        check("irq status", 32'h1, d);
        cycles(2);
        check("irq cleared", 0, irq);
        bus_rd(`REG_IRQ_MASK, d);
        check("mask readback", 32'h1, d);
        bus_wr(`REG_IRQ_MASK, 32'h0);
        u_host.query(supply_cmd_pkg::CMD_CAL_QUERY, got);
        cycles(3);
        check("irq masked", 0, irq);
        bus_wr(4'h2, 32'hffff_ffff);
        bus_rd(4'h2, d);
        check("unmapped read", 0, d);
        bus_wr(`REG_STATE, 32'h7);
        bus_rd(`REG_STATE, d);
        check("state read only", 32'h8, d);
    end
    endtask

    // ****************************************************************
    // Main sequence and hang guard.
    // ****************************************************************
    initial
    begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        cycles(3);
        t_reset;
        t_acc;
        t_aux;
        t_clear_remote;
        t_clear_local;
        t_irq;
        num_errors += u_host.lost_replies;
        finish_test;
    end

    // Cuts the run short if a wait hangs.
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        finish_test;
    end
endmodule
`default_nettype wire
